// *** verilog/dcc_pkg.sv ***
// Notes on behaviour
// - With divide-by-three and bypass clear, divide-by-two bit 0 gives oscillator clock; 1 gives oscillator halved.
// - Divide-by-three bit set divides the oscillator clock by three unless bypass is set.
// - Bypass bit 0 uses the loop synthesiser; 1 uses incoming clock directly.
// - Bias power-down bit 7 powers bias off; resets to zero.
// - Delay-line off bit resets to one; clearing it powers and enables line.
// - Lock bit reads one when locked; loop runs only while enabled.
// - Lock readback refreshes only on rising readback trigger; otherwise held.
// - Rising update trigger transfers loop settings and fine delays to loop.
package dcc_pkg;
   // ****************
   // Register offsets
   // ****************
   localparam logic [7:0] OFS_DIV      = 8'h94;
   localparam logic [7:0] OFS_SKIP     = 8'h95;
   localparam logic [7:0] OFS_BIAS     = 8'h9a;
   localparam logic [7:0] OFS_DLPWR    = 8'hc0;
   localparam logic [7:0] OFS_LOOPCFG  = 8'hc1;
   localparam logic [7:0] OFS_STAT     = 8'hc3;
   localparam logic [7:0] OFS_RDTRIG   = 8'hc7;
   localparam logic [7:0] OFS_FINEA    = 8'hcc;
   localparam logic [7:0] OFS_FINEB    = 8'hcd;
   localparam logic [7:0] OFS_UPDTRIG  = 8'hdb;
   localparam logic [7:0] OFS_IRQSTAT  = 8'he0;
   localparam logic [7:0] OFS_IRQMASK  = 8'he1;
   // ****************
   // Reset values
   // ****************
   localparam logic [7:0] RST_DLPWR    = 8'h31;
   localparam logic [7:0] RST_LOOPCFG  = 8'h70;
   localparam logic [7:0] RST_ZERO     = 8'h00;
   // ****************
   // Field positions
   // ****************
   localparam int BIT_DIV2   = 0;
   localparam int BIT_DIV3   = 1;
   localparam int BIT_BIAS   = 7;
   localparam int BIT_DLOFF  = 0;
   localparam int BIT_EN     = 0;
   // Interrupt events: lock captured, settings transferred
   localparam int IRQ_LOCK   = 0;
   localparam int IRQ_UPD    = 1;
   localparam logic [7:0] MASK_DLPWR   = 8'h31;
   localparam logic [7:0] MASK_LOOPCFG = 8'hf9;
   localparam logic [7:0] MASK_FINE    = 8'h3f;
   localparam logic [7:0] MASK_IRQ     = 8'h03;
   // Clock source select codes
   localparam logic [1:0] SRC_VCO      = 2'h0;
   localparam logic [1:0] SRC_DIV2     = 2'h1;
   localparam logic [1:0] SRC_DIV3     = 2'h2;
   localparam logic [1:0] SRC_EXT      = 2'h3;
endpackage : dcc_pkg

// *** verilog/dcc_top.sv ***
`timescale 1ns/1ps
module dcc_top
   import dcc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // Analog loop status pin
   input  wire logic        loop_locked_pin,
   // Clock path controls
   output logic [1:0]       clk_source_sel,
   output logic             bias_off,
   output logic             delay_line_off,
   output logic [1:0]       delay_line_aux,
   output logic             loop_enable,
   // Settings handed to the loop on update
   output logic [1:0]       loop_dac_setting,
   output logic             loop_search_mode,
   output logic [1:0]       loop_search_dir,
   output logic [5:0]       fine_delay_field_a,
   output logic [5:0]       fine_delay_field_b,
   output logic             loop_update_pulse,
   // Interrupt
   output logic             irq
);
   // ****************
   // Register storage
   // ****************
   logic [7:0] vco_divider_select;
   logic [7:0] synth_skip_control;
   logic [7:0] bias_power_control;
   logic [7:0] delay_line_power;
   logic [7:0] delay_loop_config;
   logic [7:0] delay_loop_status;
   logic [7:0] delay_loop_readback_trigger;
   logic [7:0] fine_delay_a;
   logic [7:0] fine_delay_b;
   logic [7:0] delay_loop_update_trigger;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic       ack;
   logic [2:0] lock_sync;

   // ****************
   // Bus decode
   // ****************
   // One wait cycle: a request is answered on its second edge
   wire        req      = (avs_read | avs_write) & ~ack;
   wire        wr_go    = avs_write & ack & avs_byteenable[0];
   wire        rd_go    = avs_read & ack;
   wire [7:0]  wd       = avs_writedata[7:0];
   wire [7:0]  a        = avs_address;
   wire        w_div    = wr_go & (a == OFS_DIV);
   wire        w_skip   = wr_go & (a == OFS_SKIP);
   wire        w_bias   = wr_go & (a == OFS_BIAS);
   wire        w_dlpwr  = wr_go & (a == OFS_DLPWR);
   wire        w_cfg    = wr_go & (a == OFS_LOOPCFG);
   wire        w_rdtrig = wr_go & (a == OFS_RDTRIG);
   wire        w_finea  = wr_go & (a == OFS_FINEA);
   wire        w_fineb  = wr_go & (a == OFS_FINEB);
   wire        w_updtrg = wr_go & (a == OFS_UPDTRIG);
   wire        w_mask   = wr_go & (a == OFS_IRQMASK);
   wire        r_irq    = rd_go & (a == OFS_IRQSTAT);

   wire rd_rise  = w_rdtrig & wd[0] & ~delay_loop_readback_trigger[0];
   wire upd_rise = w_updtrg & wd[0] & ~delay_loop_update_trigger[0];

   // Lock only meaningful while the loop controller runs
   wire lock_now = lock_sync[2] & lock_sync[1] & delay_loop_config[BIT_EN];

   wire [7:0] rd_mux =
      (a == OFS_DIV)     ? vco_divider_select :
      (a == OFS_SKIP)    ? synth_skip_control :
      (a == OFS_BIAS)    ? bias_power_control :
      (a == OFS_DLPWR)   ? delay_line_power :
      (a == OFS_LOOPCFG) ? delay_loop_config :
      (a == OFS_STAT)    ? delay_loop_status :
      (a == OFS_RDTRIG)  ? delay_loop_readback_trigger :
      (a == OFS_FINEA)   ? fine_delay_a :
      (a == OFS_FINEB)   ? fine_delay_b :
      (a == OFS_UPDTRIG) ? delay_loop_update_trigger :
      (a == OFS_IRQSTAT) ? irq_status :
      (a == OFS_IRQMASK) ? irq_mask : RST_ZERO;

   // Source priority: bypass, then divide by three, then by two
   // bypass select
   wire [1:0] next_src =
      synth_skip_control[0]        ? SRC_EXT  :
      vco_divider_select[BIT_DIV3] ? SRC_DIV3 :
      vco_divider_select[BIT_DIV2] ? SRC_DIV2 : SRC_VCO;

   wire [7:0] irq_set = {6'h00, upd_rise, rd_rise & lock_now};
   wire [7:0] next_irq_status = (r_irq ? RST_ZERO : irq_status) | irq_set;

   // ****************
   // Bus handshake
   // ****************
   // Waitrequest kept in its own flop so the pin has no gate in front
   always_ff @(posedge clk) begin
      if (rst) begin
         ack             <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         ack             <= req;
         avs_waitrequest <= ~req;
         if (req)
            avs_readdata <= {24'h00_0000, rd_mux};
      end
   end

   // ****************
   // Control registers
   // ****************
   always_ff @(posedge clk) begin
      if (rst) begin
         vco_divider_select <= RST_ZERO;
         synth_skip_control <= RST_ZERO;
         bias_power_control <= RST_ZERO;
         delay_line_power   <= RST_DLPWR;
         delay_loop_config  <= RST_LOOPCFG;
         fine_delay_a       <= RST_ZERO;
         fine_delay_b       <= RST_ZERO;
         irq_mask           <= RST_ZERO;
      end else begin
         if (w_div)   vco_divider_select <= wd & 8'h03;
         if (w_skip)  synth_skip_control <= wd & 8'h01;
         if (w_bias)  bias_power_control <= wd;
         if (w_dlpwr) delay_line_power   <= wd & MASK_DLPWR;
         if (w_cfg)   delay_loop_config  <= wd & MASK_LOOPCFG;
         if (w_finea) fine_delay_a       <= wd & MASK_FINE;
         if (w_fineb) fine_delay_b       <= wd & MASK_FINE;
         if (w_mask)  irq_mask           <= wd & MASK_IRQ;
      end
   end

   // ****************
   // Triggers and lock
   // ****************
   always_ff @(posedge clk) begin
      if (rst) begin
         delay_loop_readback_trigger <= RST_ZERO;
         delay_loop_update_trigger   <= RST_ZERO;
         delay_loop_status           <= RST_ZERO;
         lock_sync                   <= 3'h0;
         irq_status                  <= RST_ZERO;
      end else begin
         lock_sync <= {lock_sync[1:0], loop_locked_pin};
         if (w_rdtrig) delay_loop_readback_trigger <= wd & 8'h01;
         if (w_updtrg) delay_loop_update_trigger   <= wd & 8'h01;
         if (rd_rise) delay_loop_status <= {7'h00, lock_now};
         // Set wins over clear-on-read
         irq_status <= next_irq_status;
      end
   end

   // ****************
   // Outputs
   // ****************
   always_ff @(posedge clk) begin
      if (rst) begin
         clk_source_sel     <= SRC_VCO;
         bias_off           <= 1'b0;
         delay_line_off     <= 1'b1;
         delay_line_aux     <= 2'h3;
         loop_enable        <= 1'b0;
         loop_dac_setting   <= 2'h1;
         loop_search_mode   <= 1'b1;
         loop_search_dir    <= 2'h2;
         fine_delay_field_a <= 6'h00;
         fine_delay_field_b <= 6'h00;
         loop_update_pulse  <= 1'b0;
         irq                <= 1'b0;
      end else begin
         clk_source_sel <= next_src;
         bias_off       <= bias_power_control[BIT_BIAS];
         delay_line_off <= delay_line_power[BIT_DLOFF];
         delay_line_aux <= delay_line_power[5:4];
         loop_enable    <= delay_loop_config[BIT_EN];
         if (upd_rise) begin
            loop_dac_setting   <= delay_loop_config[7:6];
            loop_search_mode   <= delay_loop_config[5];
            loop_search_dir    <= delay_loop_config[4:3];
            fine_delay_field_a <= fine_delay_a[5:0];
            fine_delay_field_b <= fine_delay_b[5:0];
         end
         loop_update_pulse <= upd_rise;
         irq <= |(next_irq_status & irq_mask);
      end
   end
endmodule : dcc_top

// *** verification/dcc_chk.sv ***
`timescale 1ns/1ps
module dcc_chk
   import dcc_pkg::*;
(
   // Bus
   input wire logic        clk, rst, avs_read, avs_write, avs_waitrequest,
   input wire logic [7:0]  avs_address,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   // Controls
   input wire logic [1:0]  clk_source_sel,
   input wire logic        bias_off, delay_line_off, loop_enable,
   input wire logic [5:0]  fine_delay_field_a,
   input wire logic        loop_update_pulse
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ****************
   // Accepted writes
   // ****************
   logic wr;
   logic upd_wr;
   assign wr     = avs_write & ~avs_waitrequest & avs_byteenable[0];
   assign upd_wr = wr & (avs_address == OFS_UPDTRIG) & avs_writedata[0];
   property p_wait;
      (avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest;
   endproperty
   a_wait: assert property (p_wait) else $error("request not answered");
   property p_wait2;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_wait2: assert property (p_wait2) else $error("answer too long");
   // Two cycles allows for a registered output stage
   property p_src;
      wr && avs_address == OFS_SKIP && avs_writedata[0]
         |-> ##2 clk_source_sel == SRC_EXT;
   endproperty
   a_src: assert property (p_src) else $error("source not external");
   property p_bias;
      wr && avs_address == OFS_BIAS
         |-> ##2 bias_off == $past(avs_writedata[BIT_BIAS], 2);
   endproperty
   a_bias: assert property (p_bias) else $error("bias off wrong");
   property p_dloff;
      wr && avs_address == OFS_DLPWR
         |-> ##2 delay_line_off == $past(avs_writedata[0], 2);
   endproperty
   a_dloff: assert property (p_dloff) else $error("line off wrong");
   property p_en;
      wr && avs_address == OFS_LOOPCFG
         |-> ##2 loop_enable == $past(avs_writedata[0], 2);
   endproperty
   a_en: assert property (p_en) else $error("enable wrong");
   property p_pulse;
      loop_update_pulse
         |-> ($past(upd_wr) || $past(upd_wr, 2)) ##1 !loop_update_pulse;
   endproperty
   a_pulse: assert property (p_pulse) else $error("bad pulse");
   property p_hold;
      !$past(upd_wr) && !$past(upd_wr, 2) && !$past(upd_wr, 3)
         |-> $stable(fine_delay_field_a);
   endproperty
   a_hold: assert property (p_hold) else $error("delay moved");
endmodule : dcc_chk

bind dcc_top dcc_chk chk_u (.*);

// *** verification/tb_dac_clock_pll_dll_control.sv ***
`timescale 1ns/1ps
module tb_dac_clock_pll_dll_control
   import dcc_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0]  avs_byteenable = 4'hf;
   logic        loop_locked_pin = 1'b0;
   logic [31:0] avs_readdata, rd_val;
   logic        avs_waitrequest, loop_update_pulse, irq, bias_off;
   logic        delay_line_off, loop_enable, loop_search_mode;
   logic [1:0]  clk_source_sel, delay_line_aux, loop_dac_setting;
   logic [1:0]  loop_search_dir;
   logic [5:0]  fine_delay_field_a, fine_delay_field_b;
   int          err_count = 0;
   int          n_compared = 0;
   int          n_pulse = 0;
   logic [7:0]  src_d[4] = '{8'h01, 8'h02, 8'h03, 8'hff};
   logic [1:0]  src_e[4] = '{SRC_DIV2, SRC_DIV3, SRC_DIV3, SRC_DIV3};
   always #10 clk = ~clk;
   always @(posedge clk) if (loop_update_pulse === 1'b1) n_pulse++;
   dcc_top dut_u (.*);
   // ****************
   // Bus tasks
   // ****************
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Idle edge at the end lets registered outputs settle before checks
   task automatic xfer(input logic rw, input logic [7:0] a, d);
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= {24'h00_0000, d};
      avs_write     <= rw;
      avs_read      <= ~rw;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd_val = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
      @(negedge clk);
   endtask : xfer
   task automatic wr(input logic [7:0] a, d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), e, rd_val);
   endtask : rdc
   task automatic conclude;
      if (err_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   initial begin
      #100_000;
      err_count++;
      conclude;
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk("aux", 2'h3, delay_line_aux);
      chk("dir", 2'h2, loop_search_dir);
      chk("dac", 2'h1, loop_dac_setting);
      rdc(OFS_DLPWR, RST_DLPWR);
      rdc(OFS_LOOPCFG, RST_LOOPCFG);
      rdc(OFS_BIAS, RST_ZERO);
      rdc(OFS_STAT, RST_ZERO);
      foreach (src_d[i]) begin
         wr(OFS_DIV, src_d[i]);
         chk("source", src_e[i], clk_source_sel);
      end
      rdc(OFS_DIV, 8'h03);
      wr(OFS_SKIP, 8'hff);
      chk("source", SRC_EXT, clk_source_sel);
      rdc(OFS_SKIP, 8'h01);
      wr(OFS_SKIP, 8'h00);
      wr(OFS_DIV, 8'h00);
      chk("source", SRC_VCO, clk_source_sel);
      wr(OFS_BIAS, 8'h80);
      chk("bias", 1'h1, bias_off);
      wr(OFS_BIAS, 8'h7f);
      chk("bias", 1'h0, bias_off);
      rdc(OFS_BIAS, 8'h7f);
      @(posedge clk) avs_byteenable <= 4'he;
      wr(OFS_BIAS, 8'h80);
      @(posedge clk) avs_byteenable <= 4'hf;
      chk("bias", 1'h0, bias_off);
      wr(8'h96, 8'hff);
      rdc(8'h96, 8'h00);
      wr(OFS_DLPWR, 8'hce);
      chk("line off", 1'h0, delay_line_off);
      chk("aux", 2'h0, delay_line_aux);
      rdc(OFS_DLPWR, 8'h00);
      wr(OFS_LOOPCFG, 8'h49);
      chk("enable", 1'h1, loop_enable);
      chk("dir", 2'h2, loop_search_dir);
      wr(OFS_FINEA, 8'hff);
      wr(OFS_FINEB, 8'h15);
      rdc(OFS_FINEA, 8'h3f);
      chk("fine a", 6'h00, fine_delay_field_a);
      wr(OFS_IRQMASK, 8'h03);
      wr(OFS_UPDTRIG, 8'h01);
      chk("pulses", 32'h0000_0001, n_pulse);
      chk("fine a", 6'h3f, fine_delay_field_a);
      chk("fine b", 6'h15, fine_delay_field_b);
      chk("mode", 1'h0, loop_search_mode);
      chk("dir", 2'h1, loop_search_dir);
      chk("irq", 1'h1, irq);
      rdc(OFS_IRQSTAT, 8'h02);
      wr(OFS_UPDTRIG, 8'h01);
      chk("pulses", 32'h0000_0001, n_pulse);
      chk("irq", 1'h0, irq);
      @(posedge clk) loop_locked_pin <= 1'b1;
      repeat (4) @(posedge clk);
      wr(OFS_RDTRIG, 8'h01);
      rdc(OFS_STAT, 8'h01);
      rdc(OFS_IRQSTAT, 8'h01);
      @(posedge clk) loop_locked_pin <= 1'b0;
      repeat (4) @(posedge clk);
      rdc(OFS_STAT, 8'h01);
      wr(OFS_RDTRIG, 8'h01);
      rdc(OFS_STAT, 8'h01);
      wr(OFS_RDTRIG, 8'h00);
      wr(OFS_RDTRIG, 8'h01);
      rdc(OFS_STAT, 8'h00);
      wr(OFS_IRQMASK, 8'h00);
      wr(OFS_UPDTRIG, 8'h00);
      wr(OFS_UPDTRIG, 8'h01);
      chk("pulses", 32'h0000_0002, n_pulse);
      chk("irq", 1'h0, irq);
      rdc(OFS_IRQSTAT, 8'h02);
      conclude;
   end
endmodule : tb_dac_clock_pll_dll_control
